// *** src/oag_pkg.sv ***
// constants and types for operand address generation
// assumes one core clock and an internal byte-wide memory bus
// How it works
// RULE1 - ten modes, chosen from opcode alone
// RULE2 - operand accessed at the operand location; bit test mode accesses its direct byte instead
// RULE3 - instructions at most three bytes long
// RULE4 - opcode only mode: one byte, no operand
// RULE5 - literal operand: location PC+1, PC+=2
// RULE6 - direct: high zero, low byte, PC+=2
// RULE7 - full address: high, low bytes, PC+=3
// RULE8 - index pointer: high zero, low X, PC+=1
// RULE9 - half carry is carry out of bit3
// RULE10 - mode classified from opcode upper nibble
// RULE11 - sixteen bit bus in two halves
package oag_pkg;
  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [9:0] {
    OAG_BTB  = 10'h001,
    OAG_BSC  = 10'h002,
    OAG_REL  = 10'h004,
    OAG_DIR  = 10'h008,
    OAG_OPCODE_ONLY  = 10'h010,
    OAG_INDEX_POINTER = 10'h020,
    OAG_IX1  = 10'h040,
    OAG_LITERAL_OPERAND = 10'h080,
    OAG_FULL_ADDRESS  = 10'h100,
    OAG_IX2  = 10'h200
  } oag_mode_t;

  // ****************************************
  // state machine
  // ****************************************
  typedef enum logic [4:0] {
    OAG_S_FETCH = 5'h01,
    OAG_S_BYTE1 = 5'h02,
    OAG_S_BYTE2 = 5'h04,
    OAG_S_OPER  = 5'h08,
    OAG_S_DONE  = 5'h10
  } oag_state_t;

  localparam logic [15:0] OAG_PC_RESET   = 16'h0000;
  localparam logic [15:0] OAG_PC_STEP1   = 16'h0001;
  localparam logic [15:0] OAG_PC_STEP2   = 16'h0002;
  localparam logic [15:0] OAG_PC_STEP3   = 16'h0003;
  localparam logic [7:0]  OAG_HIGH_ZERO  = 8'h00;
  localparam int          OAG_NIB_HI     = 7;
  localparam int          OAG_NIB_LO     = 4;
  localparam int          OAG_HALF_BIT   = 4;
  localparam logic [3:0]  OAG_G_RMW_DIR  = 4'h3;
  localparam logic [3:0]  OAG_G_RMW_A    = 4'h4;
  localparam logic [3:0]  OAG_G_RMW_X    = 4'h5;
  localparam logic [3:0]  OAG_G_RMW_IX1  = 4'h6;
  localparam logic [3:0]  OAG_G_RMW_IX   = 4'h7;
  localparam logic [3:0]  OAG_G_CTL_A    = 4'h8;
  localparam logic [3:0]  OAG_G_CTL_B    = 4'h9;
  localparam logic [3:0]  OAG_G_IMM      = 4'hA;
  localparam logic [3:0]  OAG_G_DIR      = 4'hB;
  localparam logic [3:0]  OAG_G_EXT      = 4'hC;
  localparam logic [3:0]  OAG_G_IX2      = 4'hD;
  localparam logic [3:0]  OAG_G_IX1      = 4'hE;
  localparam logic [3:0]  OAG_G_BTB      = 4'h0;
  localparam logic [3:0]  OAG_G_BSC      = 4'h1;
  localparam logic [3:0]  OAG_G_REL      = 4'h2;
endpackage : oag_pkg

// *** src/oag_core.sv ***
// operand address generator: fetch, mode decode, operand location
// assumes memory answers a read in the same cycle on I_RDATA
module oag_core (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_GO,
  input  wire logic [7:0]  I_RDATA,
  input  wire logic [7:0]  I_INDEX,
  input  wire logic [7:0]  I_ADD_A,
  input  wire logic [7:0]  I_ADD_B,
  output logic      [7:0]  O_ADDR_HIGH,
  output logic      [7:0]  O_ADDR_LOW,
  output logic             O_OPER_ACCESS,
  output logic      [15:0] O_OPERAND_LOCATION,
  output logic      [15:0] O_PC,
  output logic      [9:0]  O_MODE,
  output logic      [7:0]  O_OPCODE,
  output logic             O_DONE,
  output logic             O_HALF_CARRY
);
  // ****************************************
  // opcode classification
  // ****************************************
  function automatic oag_pkg::oag_mode_t classify(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[oag_pkg::OAG_NIB_HI:oag_pkg::OAG_NIB_LO]; // [RULE10] [RULE1]
    case (hi)
      oag_pkg::OAG_G_BTB:     classify = oag_pkg::OAG_BTB;
      oag_pkg::OAG_G_BSC:     classify = oag_pkg::OAG_BSC;
      oag_pkg::OAG_G_REL:     classify = oag_pkg::OAG_REL;
      oag_pkg::OAG_G_RMW_DIR: classify = oag_pkg::OAG_DIR;
      oag_pkg::OAG_G_RMW_A,
      oag_pkg::OAG_G_RMW_X,
      oag_pkg::OAG_G_CTL_A,
      oag_pkg::OAG_G_CTL_B:   classify = oag_pkg::OAG_OPCODE_ONLY; // [RULE4]
      oag_pkg::OAG_G_RMW_IX1,
      oag_pkg::OAG_G_IX1:     classify = oag_pkg::OAG_IX1;
      oag_pkg::OAG_G_IMM:     classify = oag_pkg::OAG_LITERAL_OPERAND;
      oag_pkg::OAG_G_DIR:     classify = oag_pkg::OAG_DIR;
      oag_pkg::OAG_G_EXT:     classify = oag_pkg::OAG_FULL_ADDRESS;
      oag_pkg::OAG_G_IX2:     classify = oag_pkg::OAG_IX2;
      default:                classify = oag_pkg::OAG_INDEX_POINTER;
    endcase
  endfunction : classify

  // ****************************************
  // state
  // ****************************************
  oag_pkg::oag_state_t state_reg, state_next;
  oag_pkg::oag_mode_t  mode_reg,  mode_next;
  logic [15:0] pc_reg,  pc_next;
  logic [7:0]  op_reg,  op_next;
  logic [7:0]  b1_reg,  b1_next;
  logic [15:0] loc_reg, loc_next;
  logic [7:0]  ah_reg,  ah_next;
  logic [7:0]  al_reg,  al_next;
  logic        acc_reg, acc_next;
  logic        done_reg, done_next;
  logic        hc_reg,  hc_next;
  logic [8:0]  ix_sum;
  logic [4:0]  nib_sum;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    pc_next    = pc_reg;
    op_next    = op_reg;
    b1_next    = b1_reg;
    loc_next   = loc_reg;
    ah_next    = ah_reg;
    al_next    = al_reg;
    acc_next   = 1'b0;
    done_next  = 1'b0;
    // both sums run every cycle; only the indexed modes take ix_sum, while nib_sum feeds half carry every cycle
    ix_sum     = {1'b0, I_INDEX} + {1'b0, I_RDATA};
    nib_sum    = {1'b0, I_ADD_A[3:0]} + {1'b0, I_ADD_B[3:0]};
    hc_next    = nib_sum[oag_pkg::OAG_HALF_BIT]; // [RULE9]
    case (state_reg)
      oag_pkg::OAG_S_FETCH: begin
        {ah_next, al_next} = pc_reg; // [RULE11]
        // go outside fetch is ignored; a held level starts a new instruction each time fetch is reached
        if (I_GO) begin
          op_next   = I_RDATA;
          mode_next = classify(I_RDATA);
          case (classify(I_RDATA))
            oag_pkg::OAG_OPCODE_ONLY: begin
              pc_next    = pc_reg + oag_pkg::OAG_PC_STEP1; // [RULE4]
              state_next = oag_pkg::OAG_S_DONE;
            end
            oag_pkg::OAG_INDEX_POINTER: begin
              ah_next    = oag_pkg::OAG_HIGH_ZERO; // [RULE8]
              al_next    = I_INDEX;
              loc_next   = {oag_pkg::OAG_HIGH_ZERO, I_INDEX};
              pc_next    = pc_reg + oag_pkg::OAG_PC_STEP1;
              state_next = oag_pkg::OAG_S_OPER;
            end
            default: begin
              {ah_next, al_next} = pc_reg + oag_pkg::OAG_PC_STEP1;
              state_next = oag_pkg::OAG_S_BYTE1;
            end
          endcase
        end
      end
      oag_pkg::OAG_S_BYTE1: begin
        b1_next = I_RDATA;
        case (mode_reg)
          oag_pkg::OAG_LITERAL_OPERAND: begin
            loc_next   = pc_reg + oag_pkg::OAG_PC_STEP1; // [RULE5]
            pc_next    = pc_reg + oag_pkg::OAG_PC_STEP2;
            acc_next   = 1'b1;
            state_next = oag_pkg::OAG_S_DONE;
          end
          oag_pkg::OAG_DIR, oag_pkg::OAG_BSC: begin
            ah_next    = oag_pkg::OAG_HIGH_ZERO; // [RULE6]
            al_next    = I_RDATA;
            loc_next   = {oag_pkg::OAG_HIGH_ZERO, I_RDATA};
            pc_next    = pc_reg + oag_pkg::OAG_PC_STEP2;
            state_next = oag_pkg::OAG_S_OPER;
          end
          oag_pkg::OAG_IX1: begin
            ah_next    = {7'h00, ix_sum[8]};
            al_next    = ix_sum[7:0];
            loc_next   = {7'h00, ix_sum};
            pc_next    = pc_reg + oag_pkg::OAG_PC_STEP2;
            state_next = oag_pkg::OAG_S_OPER;
          end
          oag_pkg::OAG_REL: begin
            // target only; no branch condition is known here, so pc steps past the two bytes, not to the target
            loc_next   = pc_reg + oag_pkg::OAG_PC_STEP2 + {{8{I_RDATA[7]}}, I_RDATA};
            pc_next    = pc_reg + oag_pkg::OAG_PC_STEP2;
            state_next = oag_pkg::OAG_S_DONE;
          end
          default: begin
            {ah_next, al_next} = pc_reg + oag_pkg::OAG_PC_STEP2; // [RULE3]
            state_next = oag_pkg::OAG_S_BYTE2;
          end
        endcase
      end
      oag_pkg::OAG_S_BYTE2: begin
        pc_next    = pc_reg + oag_pkg::OAG_PC_STEP3; // [RULE3]
        state_next = oag_pkg::OAG_S_OPER;
        case (mode_reg)
          oag_pkg::OAG_FULL_ADDRESS: begin
            ah_next  = b1_reg; // [RULE7]
            al_next  = I_RDATA;
            loc_next = {b1_reg, I_RDATA};
          end
          oag_pkg::OAG_IX2: begin
            ah_next  = b1_reg + {7'h00, ix_sum[8]};
            al_next  = ix_sum[7:0];
            loc_next = {b1_reg, 8'h00} + {7'h00, ix_sum};
          end
          default: begin
            ah_next    = oag_pkg::OAG_HIGH_ZERO; // bit test: direct byte first
            al_next    = b1_reg;
            loc_next   = pc_reg + oag_pkg::OAG_PC_STEP3 + {{8{I_RDATA[7]}}, I_RDATA};
          end
        endcase
      end
      oag_pkg::OAG_S_OPER: begin
        acc_next   = 1'b1; // [RULE2]
        state_next = oag_pkg::OAG_S_DONE;
      end
      oag_pkg::OAG_S_DONE: begin
        done_next  = 1'b1;
        // park the bus on pc so the next opcode is ready at fetch
        {ah_next, al_next} = pc_reg;
        state_next = oag_pkg::OAG_S_FETCH;
      end
      default: state_next = oag_pkg::OAG_S_FETCH;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= oag_pkg::OAG_S_FETCH;
      mode_reg  <= oag_pkg::OAG_OPCODE_ONLY;
      pc_reg    <= oag_pkg::OAG_PC_RESET;
      op_reg    <= 8'h00;
      b1_reg    <= 8'h00;
      loc_reg   <= 16'h0000;
      ah_reg    <= 8'h00;
      al_reg    <= 8'h00;
      acc_reg   <= 1'b0;
      done_reg  <= 1'b0;
      hc_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      pc_reg    <= pc_next;
      op_reg    <= op_next;
      b1_reg    <= b1_next;
      loc_reg   <= loc_next;
      ah_reg    <= ah_next;
      al_reg    <= al_next;
      acc_reg   <= acc_next;
      done_reg  <= done_next;
      hc_reg    <= hc_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_ADDR_HIGH        = ah_reg;
  assign O_ADDR_LOW         = al_reg;
  assign O_OPER_ACCESS      = acc_reg;
  assign O_OPERAND_LOCATION = loc_reg;
  assign O_PC               = pc_reg;
  assign O_MODE             = mode_reg;
  assign O_OPCODE           = op_reg;
  assign O_DONE             = done_reg;
  assign O_HALF_CARRY       = hc_reg;
endmodule : oag_core

// *** dv/oag_mem.sv ***
// byte-wide memory seen by the address generator
// assumes a read answers in the same cycle, as the core expects
module oag_mem (
  input  wire logic [7:0] i_addr_high,
  input  wire logic [7:0] i_addr_low,
  output logic      [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // ****
  // unwritten bytes hold a pattern, never x
  // ****
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'hA5 ^ a[7:0];
    end
  end
  assign o_rdata = mem[{i_addr_high, i_addr_low}];
endmodule : oag_mem

// *** dv/oag_core_sva.sv ***
// checker for the operand address generator
// assumes it is bound to oag_core with one clock
module oag_core_sva (
  input wire logic        I_CORE_CLK,
  input wire logic        I_ARST_N,
  input wire logic [7:0]  I_INDEX,
  input wire logic [7:0]  I_ADD_A,
  input wire logic [7:0]  I_ADD_B,
  input wire logic [7:0]  O_ADDR_HIGH,
  input wire logic [7:0]  O_ADDR_LOW,
  input wire logic        O_OPER_ACCESS,
  input wire logic [15:0] O_OPERAND_LOCATION,
  input wire logic [15:0] O_PC,
  input wire logic [9:0]  O_MODE,
  input wire logic        O_DONE,
  input wire logic        O_HALF_CARRY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_acc_done;
    O_OPER_ACCESS ##1 O_DONE;
  endsequence
  a_mode_one_hot: assert property ($onehot(O_MODE)) else $error("mode not one-hot");
  a_access_done: assert property (O_OPER_ACCESS |-> s_acc_done) else $error("no done");
  a_bus_at_loc: assert property (O_OPER_ACCESS && O_MODE != oag_pkg::OAG_BTB
    |-> {O_ADDR_HIGH, O_ADDR_LOW} == O_OPERAND_LOCATION)
    else $error("bus off location");
  a_btb_page: assert property (O_OPER_ACCESS && O_MODE == oag_pkg::OAG_BTB
    |-> O_ADDR_HIGH == 8'h00) else $error("bit test high");
  a_done_pulse: assert property (O_DONE |=> !O_DONE && !O_OPER_ACCESS) else $error("long done");
  a_lit_location: assert property (O_OPER_ACCESS && O_MODE == oag_pkg::OAG_LITERAL_OPERAND
    |-> O_OPERAND_LOCATION == O_PC - 16'h0001) else $error("literal location");
  a_direct_page: assert property (O_OPER_ACCESS && O_MODE == oag_pkg::OAG_DIR
    |-> O_ADDR_HIGH == 8'h00) else $error("direct high");
  a_full_pc: assert property (O_OPER_ACCESS && O_MODE == oag_pkg::OAG_FULL_ADDRESS
    |=> {O_ADDR_HIGH, O_ADDR_LOW} == O_PC) else $error("full pc");
  a_index_loc: assert property (O_OPER_ACCESS && O_MODE == oag_pkg::OAG_INDEX_POINTER
    |-> O_OPERAND_LOCATION == {8'h00, I_INDEX}) else $error("index location");
  a_opcode_only: assert property (O_DONE && O_MODE == oag_pkg::OAG_OPCODE_ONLY
    |-> !$past(O_OPER_ACCESS)) else $error("opcode only access");
  a_half_carry: assert property (##1 O_HALF_CARRY ==
    $past(({1'b0, I_ADD_A[3:0]} + {1'b0, I_ADD_B[3:0]}) > 5'h0F)) else $error("half carry");
endmodule : oag_core_sva
bind oag_core oag_core_sva i_sva (.I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
  .I_INDEX(I_INDEX), .I_ADD_A(I_ADD_A), .I_ADD_B(I_ADD_B), .O_ADDR_HIGH(O_ADDR_HIGH),
  .O_ADDR_LOW(O_ADDR_LOW), .O_OPER_ACCESS(O_OPER_ACCESS),
  .O_OPERAND_LOCATION(O_OPERAND_LOCATION), .O_PC(O_PC), .O_MODE(O_MODE), .O_DONE(O_DONE),
  .O_HALF_CARRY(O_HALF_CARRY));

// *** dv/operand_address_generation_bench.sv ***
// self-checking bench for the operand address generator
// assumes oag_mem answers reads combinationally
module operand_address_generation_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, go, acc, done, hc;
  logic [7:0]  index, add_a, add_b, rdata, a_hi, a_lo, opc;
  logic [15:0] loc, pc, exp_pc;
  logic [9:0]  mode;
  int          fail_count, samples_checked;
  oag_core i_dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_GO(go), .I_RDATA(rdata),
    .I_INDEX(index), .I_ADD_A(add_a), .I_ADD_B(add_b), .O_ADDR_HIGH(a_hi),
    .O_ADDR_LOW(a_lo), .O_OPER_ACCESS(acc), .O_OPERAND_LOCATION(loc), .O_PC(pc),
    .O_MODE(mode), .O_OPCODE(opc), .O_DONE(done), .O_HALF_CARRY(hc));
  oag_mem i_mem (.i_addr_high(a_hi), .i_addr_low(a_lo), .o_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // ****
  // one instruction: load bytes at pc, take it, time it, check location and pc
  // ****
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                     input logic [9:0] m, input logic [15:0] l, input logic [15:0] step,
                     input logic [15:0] lat);
    logic [15:0] n;
    logic [15:0] seen;
    logic [15:0] bus;
    logic        quiet;
    i_mem.mem[exp_pc] = op;
    i_mem.mem[exp_pc + 16'h0001] = b1;
    i_mem.mem[exp_pc + 16'h0002] = b2;
    quiet = (m == oag_pkg::OAG_OPCODE_ONLY) || (m == oag_pkg::OAG_REL);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    // the taking edge counts as the first cycle
    n = 16'h0001;
    seen = 16'h0000;
    bus = 16'h0000;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (acc === 1'b1) begin
        seen++;
        bus = {a_hi, a_lo};
      end
    end while (done !== 1'b1 && n < 16'h0009);
    chk(n, lat);
    chk({6'h00, mode}, {6'h00, m});
    chk({8'h00, opc}, {8'h00, op});
    if (m != oag_pkg::OAG_OPCODE_ONLY) chk(loc, l);
    chk(seen, quiet ? 16'h0000 : 16'h0001);
    if (m == oag_pkg::OAG_BTB) chk(bus, {8'h00, b1});
    else if (!quiet) chk(bus, l);
    exp_pc = exp_pc + step;
    chk(pc, exp_pc);
    chk({a_hi, a_lo}, exp_pc);
  endtask : run
  task automatic t_opcode_only();
    run(8'h9D, 8'h00, 8'h00, oag_pkg::OAG_OPCODE_ONLY, 16'h0000, 16'h0001, 16'h0002);
  endtask : t_opcode_only
  task automatic t_literal();
    run(8'hA6, 8'h3C, 8'h00, oag_pkg::OAG_LITERAL_OPERAND, exp_pc + 16'h0001, 16'h0002,
        16'h0003);
  endtask : t_literal
  task automatic t_direct();
    run(8'hB6, 8'hFF, 8'h00, oag_pkg::OAG_DIR, 16'h00FF, 16'h0002, 16'h0004);
  endtask : t_direct
  task automatic t_full();
    run(8'hC6, 8'h12, 8'h34, oag_pkg::OAG_FULL_ADDRESS, 16'h1234, 16'h0003, 16'h0005);
  endtask : t_full
  task automatic t_index();
    run(8'hF6, 8'h00, 8'h00, oag_pkg::OAG_INDEX_POINTER, 16'h00FF, 16'h0001, 16'h0003);
  endtask : t_index
  task automatic t_offsets();
    run(8'hE6, 8'hF0, 8'h00, oag_pkg::OAG_IX1, 16'h01EF, 16'h0002, 16'h0004);
    run(8'hD6, 8'h12, 8'hF0, oag_pkg::OAG_IX2, 16'h13EF, 16'h0003, 16'h0005);
    run(8'h10, 8'h80, 8'h00, oag_pkg::OAG_BSC, 16'h0080, 16'h0002, 16'h0004);
    run(8'h20, 8'hFE, 8'h00, oag_pkg::OAG_REL, exp_pc, 16'h0002, 16'h0003);
    run(8'h00, 8'h40, 8'h05, oag_pkg::OAG_BTB, exp_pc + 16'h0008, 16'h0003, 16'h0005);
  endtask : t_offsets
  task automatic t_half_carry();
    @(posedge clk) begin add_a <= 8'h08; add_b <= 8'hF8; end
    @(posedge clk);
    #1 chk({15'h0000, hc}, 16'h0001);
    @(posedge clk) begin add_a <= 8'h07; add_b <= 8'hF8; end
    @(posedge clk);
    #1 chk({15'h0000, hc}, 16'h0000);
  endtask : t_half_carry
  initial begin
    {rst_n, go, index, add_a, add_b, exp_pc} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    index <= 8'hFF;
    t_opcode_only();
    t_literal();
    t_direct();
    t_full();
    t_index();
    t_offsets();
    t_half_carry();
    t_full();
    results();
  end
  // watchdog at 2000 cycles, well beyond the fewer than one hundred cycles the tests need
  initial begin
    #40000;
    fail_count++;
    results();
  end
endmodule : operand_address_generation_bench
